// ===== core/cce_comparator_ctrl.sv
// comparator control, status, edge events and mask-source select behind an axi4-lite slave
// Operation
// - three channels, own registers, shared status
// - halt_in_idle stops all comparators in idle
// - status bits 10..8 show event flags
// - status bits 2..0 show adjusted results
// - control bit 15 enables the comparator
// - control bit 14 drives result pin while bit 15 is set
// - control bit 13 inverts the comparator output
// - bit 8 reads polarity-adjusted comparator result
// - event bit set on event, blocks further
// - edge select 11 fires on any change
// - edge select 10 fires on falling edge
// - edge select 01 fires on rising edge
// - edge select 00 fires nothing
// - control bit 4 selects plus input
// - control bits 1..0 select minus input
// - mask fields pick one of six pwm
// - unimplemented bits ignore writes, read zero
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`include "cce_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module cce_comparator_ctrl
    import cce_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic idle_mode,
    input wire logic [2:0] cmp_raw,
    input wire logic pwm_low1,
    input wire logic pwm_high1,
    input wire logic pwm_low2,
    input wire logic pwm_high2,
    input wire logic pwm_low3,
    input wire logic pwm_high3,
    output logic [2:0] cmp_active,
    output logic [2:0] plus_input_source,
    output logic [5:0] minus_input_select,
    output logic [2:0] result_pin,
    output logic [2:0] result_pin_oe,
    output logic [2:0] mask_a_source,
    output logic [2:0] mask_b_source,
    output logic [2:0] mask_c_source,
    output logic [2:0] cmp_trigger,
    output logic [2:0] cmp_irq
);

    // register state
    logic halt_in_idle;
    logic [2:0] cmp_enable;
    logic [2:0] pin_drive_enable;
    logic [2:0] output_invert;
    logic [2:0] event_latched;
    logic [2:0] cmp_result;
    cce_edge_sel_t event_edge_select [3];
    logic [2:0] plus_src;
    logic [1:0] minus_sel [3];
    cce_mask_code_t mask_a_code [3];
    cce_mask_code_t mask_b_code [3];
    cce_mask_code_t mask_c_code [3];

    // input synchroniser and agreement filter
    logic [2:0] raw_s1;
    logic [2:0] raw_s2;
    logic [2:0] raw_s3;
    logic [2:0] cmp_val;
    logic [2:0] adj;
    logic [2:0] run;
    logic [2:0] run_q;
    logic [2:0] hit;
    logic [5:0] pwm_vec;

    // bus state
    cce_wr_state_t wr_state;
    cce_rd_state_t rd_state;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic aw_hs;
    logic w_hs;
    logic wr_do;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    assign pwm_vec = {pwm_high3, pwm_low3, pwm_high2, pwm_low2, pwm_high1, pwm_low1};

    function automatic logic pick_pwm(input cce_mask_code_t code, input logic [5:0] src);
        logic v;
        v = 1'b0;
        // reserved codes select nothing
        if (code <= `CCE_MS_LAST_CODE) begin
            v = src[code[2:0]];
        end
        return v;
    endfunction

    function automatic logic [15:0] status_word(input logic h, input logic [2:0] e,
                                                input logic [2:0] r);
        logic [15:0] v;
        v = `CCE_REG_RESET;
        v[`CCE_ST_HALT_BIT] = h;
        v[`CCE_ST_EVT_LSB +: 3] = e;
        v[`CCE_ST_RES_LSB +: 3] = r;
        return v;
    endfunction

    // a change counts only once the second and third stage agree
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            raw_s1 <= 3'h0;
            raw_s2 <= 3'h0;
            raw_s3 <= 3'h0;
            cmp_val <= 3'h0;
        end else begin
            raw_s1 <= cmp_raw;
            raw_s2 <= raw_s1;
            raw_s3 <= raw_s2;
            cmp_val <= (raw_s2 & raw_s3) | (cmp_val & (raw_s2 ^ raw_s3));
        end
    end

    always_comb begin
        adj = cmp_val ^ output_invert;
        for (int i = 0; i < 3; i++) begin
            run[i] = cmp_enable[i] & ~(halt_in_idle & idle_mode);
        end
    end

    // edge detect against the previous adjusted result
    always_comb begin
        logic rise;
        logic fall;
        logic match;
        rise = 1'b0;
        fall = 1'b0;
        match = 1'b0;
        for (int i = 0; i < 3; i++) begin
            rise = adj[i] & ~cmp_result[i];
            fall = ~adj[i] & cmp_result[i];
            unique case (event_edge_select[i])
                2'b11: match = rise | fall;
                2'b10: match = fall;
                2'b01: match = rise;
                2'b00: match = 1'b0;
            endcase
            // first cycle after enable or wake is not an edge
            hit[i] = run[i] & run_q[i] & ~event_latched[i] & match;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            run_q <= 3'h0;
            cmp_result <= 3'h0;
        end else begin
            run_q <= run;
            for (int i = 0; i < 3; i++) begin
                if (!cmp_enable[i]) begin
                    cmp_result[i] <= 1'b0;
                end else if (run[i]) begin
                    cmp_result[i] <= adj[i];
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cmp_trigger <= 3'h0;
            cmp_irq <= 3'h0;
        end else begin
            cmp_trigger <= hit;
            cmp_irq <= hit;
        end
    end

    // pin and analog mux drive
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cmp_active <= 3'h0;
            plus_input_source <= 3'h0;
            minus_input_select <= 6'h00;
            result_pin <= 3'h0;
            result_pin_oe <= 3'h0;
            mask_a_source <= 3'h0;
            mask_b_source <= 3'h0;
            mask_c_source <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                cmp_active[i] <= run[i];
                plus_input_source[i] <= plus_src[i];
                minus_input_select[2*i +: 2] <= minus_sel[i];
                result_pin[i] <= pin_drive_enable[i] & cmp_enable[i] & cmp_result[i];
                result_pin_oe[i] <= pin_drive_enable[i] & cmp_enable[i];
                mask_a_source[i] <= pick_pwm(mask_a_code[i], pwm_vec);
                mask_b_source[i] <= pick_pwm(mask_b_code[i], pwm_vec);
                mask_c_source[i] <= pick_pwm(mask_c_code[i], pwm_vec);
            end
        end
    end

    // write path: address and data may come in either order
    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;

    always_comb begin
        wr_addr = aw_got ? aw_addr_q : s_axi_awaddr;
        wr_data = w_got ? w_data_q : s_axi_wdata;
        wr_strb = w_got ? w_strb_q : s_axi_wstrb;
        wr_do = (wr_state == cce_wr_idle) & (aw_got | aw_hs) & (w_got | w_hs);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_state <= cce_wr_idle;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CCE_RESP_OKAY;
        end else begin
            unique case (wr_state)
                cce_wr_idle: begin
                    if (aw_hs) begin
                        aw_got <= 1'b1;
                        aw_addr_q <= s_axi_awaddr;
                        s_axi_awready <= 1'b0;
                    end
                    if (w_hs) begin
                        w_got <= 1'b1;
                        w_data_q <= s_axi_wdata;
                        w_strb_q <= s_axi_wstrb;
                        s_axi_wready <= 1'b0;
                    end
                    if (wr_do) begin
                        wr_state <= cce_wr_resp;
                        s_axi_awready <= 1'b0;
                        s_axi_wready <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= (wr_addr[1:0] == 2'h0 && wr_addr <= `CCE_OFS_LAST) ?
                                       `CCE_RESP_OKAY : `CCE_RESP_SLVERR;
                    end
                end
                cce_wr_resp: begin
                    if (s_axi_bready) begin
                        wr_state <= cce_wr_idle;
                        aw_got <= 1'b0;
                        w_got <= 1'b0;
                        s_axi_bvalid <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready <= 1'b1;
                    end
                end
            endcase
        end
    end

    // shared status register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            halt_in_idle <= 1'b0;
        end else if (wr_do && wr_addr == `CCE_OFS_STATUS && wr_strb[1]) begin
            halt_in_idle <= wr_data[`CCE_ST_HALT_BIT];
        end
    end

    // per-channel control and mask-source registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cmp_enable <= 3'h0;
            pin_drive_enable <= 3'h0;
            output_invert <= 3'h0;
            event_latched <= 3'h0;
            plus_src <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                event_edge_select[i] <= 2'h0;
                minus_sel[i] <= 2'h0;
                mask_a_code[i] <= 4'h0;
                mask_b_code[i] <= 4'h0;
                mask_c_code[i] <= 4'h0;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_do && wr_addr == 8'(`CCE_OFS_CTRL1 + i * `CCE_CTRL_STEP)) begin
                    if (wr_strb[1]) begin
                        cmp_enable[i] <= wr_data[`CCE_CT_EN_BIT];
                        pin_drive_enable[i] <= wr_data[`CCE_CT_PDRV_BIT];
                        output_invert[i] <= wr_data[`CCE_CT_INV_BIT];
                        event_latched[i] <= wr_data[`CCE_CT_EVT_BIT];
                    end
                    if (wr_strb[0]) begin
                        event_edge_select[i] <= wr_data[`CCE_CT_ESEL_LSB +: 2];
                        plus_src[i] <= wr_data[`CCE_CT_PSRC_BIT];
                        minus_sel[i] <= wr_data[`CCE_CT_MSEL_LSB +: 2];
                    end
                end
                // hardware set wins over a clearing write in the same cycle
                if (hit[i]) begin
                    event_latched[i] <= 1'b1;
                end
                if (wr_do && wr_addr == 8'(`CCE_OFS_MSK1 + i * `CCE_CTRL_STEP)) begin
                    if (wr_strb[0]) begin
                        mask_a_code[i] <= wr_data[`CCE_MS_A_LSB +: 4];
                        mask_b_code[i] <= wr_data[`CCE_MS_B_LSB +: 4];
                    end
                    if (wr_strb[1]) begin
                        mask_c_code[i] <= wr_data[`CCE_MS_C_LSB +: 4];
                    end
                end
            end
        end
    end

    // read path
    function automatic logic [15:0] read_word(input logic [7:0] a);
        logic [15:0] v;
        v = `CCE_REG_RESET;
        if (a == `CCE_OFS_STATUS) begin
            v = status_word(halt_in_idle, event_latched, cmp_result);
        end
        for (int i = 0; i < 3; i++) begin
            if (a == 8'(`CCE_OFS_CTRL1 + i * `CCE_CTRL_STEP)) begin
                v[`CCE_CT_EN_BIT] = cmp_enable[i];
                v[`CCE_CT_PDRV_BIT] = pin_drive_enable[i];
                v[`CCE_CT_INV_BIT] = output_invert[i];
                v[`CCE_CT_EVT_BIT] = event_latched[i];
                v[`CCE_CT_RES_BIT] = cmp_result[i];
                v[`CCE_CT_ESEL_LSB +: 2] = event_edge_select[i];
                v[`CCE_CT_PSRC_BIT] = plus_src[i];
                v[`CCE_CT_MSEL_LSB +: 2] = minus_sel[i];
            end
            if (a == 8'(`CCE_OFS_MSK1 + i * `CCE_CTRL_STEP)) begin
                v[`CCE_MS_A_LSB +: 4] = mask_a_code[i];
                v[`CCE_MS_B_LSB +: 4] = mask_b_code[i];
                v[`CCE_MS_C_LSB +: 4] = mask_c_code[i];
            end
        end
        return v;
    endfunction

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rd_state <= cce_rd_idle;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CCE_RESP_OKAY;
        end else begin
            unique case (rd_state)
                cce_rd_idle: begin
                    if (s_axi_arvalid) begin
                        rd_state <= cce_rd_resp;
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata <= {16'h0000, read_word(s_axi_araddr)};
                        s_axi_rresp <= (s_axi_araddr[1:0] == 2'h0 &&
                                        s_axi_araddr <= `CCE_OFS_LAST) ?
                                       `CCE_RESP_OKAY : `CCE_RESP_SLVERR;
                    end
                end
                cce_rd_resp: begin
                    if (s_axi_rready) begin
                        rd_state <= cce_rd_idle;
                        s_axi_rvalid <= 1'b0;
                        s_axi_arready <= 1'b1;
                    end
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ===== include/cce_regs.svh
// register offsets, field positions, masks and reset values for the comparator control block
`ifndef CCE_REGS_SVH
`define CCE_REGS_SVH

`define CCE_ADDR_W 8
`define CCE_OFS_STATUS 8'h00
`define CCE_OFS_CTRL1 8'h04
`define CCE_OFS_MSK1 8'h08
`define CCE_OFS_CTRL2 8'h0c
`define CCE_OFS_MSK2 8'h10
`define CCE_OFS_CTRL3 8'h14
`define CCE_OFS_MSK3 8'h18
`define CCE_OFS_LAST 8'h18
`define CCE_CTRL_STEP 8'h08

`define CCE_ST_HALT_BIT 15
`define CCE_ST_EVT_LSB 8
`define CCE_ST_RES_LSB 0

`define CCE_CT_EN_BIT 15
`define CCE_CT_PDRV_BIT 14
`define CCE_CT_INV_BIT 13
`define CCE_CT_EVT_BIT 9
`define CCE_CT_RES_BIT 8
`define CCE_CT_ESEL_LSB 6
`define CCE_CT_PSRC_BIT 4
`define CCE_CT_MSEL_LSB 0

`define CCE_MS_A_LSB 0
`define CCE_MS_B_LSB 4
`define CCE_MS_C_LSB 8
`define CCE_MS_LAST_CODE 4'h5

`define CCE_STATUS_WMASK 16'h8000
`define CCE_CTRL_WMASK 16'he2d3
`define CCE_MSK_WMASK 16'h0fff
`define CCE_REG_RESET 16'h0000

`define CCE_RESP_OKAY 2'h0
`define CCE_RESP_SLVERR 2'h2

`endif

// ===== include/cce_pkg.sv
// types shared by the comparator control block
package cce_pkg;
    typedef enum logic [1:0] {
        cce_wr_idle = 2'b01,
        cce_wr_resp = 2'b10
    } cce_wr_state_t;
    typedef enum logic [1:0] {
        cce_rd_idle = 2'b01,
        cce_rd_resp = 2'b10
    } cce_rd_state_t;
    typedef logic [1:0] cce_edge_sel_t;
    typedef logic [3:0] cce_mask_code_t;
endpackage

// ===== tb/cce_props.sv
// assertions on the ports of the comparator control block
`timescale 1ns/1ps
`default_nettype none
module cce_props (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] cmp_active,
    input wire logic [2:0] result_pin,
    input wire logic [2:0] result_pin_oe,
    input wire logic [2:0] cmp_trigger,
    input wire logic [2:0] cmp_irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_trig_irq_same: assert property (cmp_trigger == cmp_irq)
        else $error("trigger and irq differ");
    a_trig_one_pulse: assert property ((cmp_trigger & $past(cmp_trigger)) == 3'h0)
        else $error("trigger longer than one cycle");
    // trigger and active both register the same running cycle
    a_trig_when_run: assert property ((cmp_trigger & ~cmp_active) == 3'h0)
        else $error("trigger from a stopped comparator");
    a_pin_gated: assert property ((result_pin & ~result_pin_oe) == 3'h0)
        else $error("result pin high while not driven");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before taken");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_ready_returns: assert property (s_axi_bvalid && s_axi_bready |=>
        s_axi_awready && s_axi_wready)
        else $error("write channels not ready again");
    c_event: cover property (cmp_trigger[0]);
    c_halt: cover property ($fell(cmp_active[0]));
    c_pin_high: cover property (result_pin[0]);
endmodule
bind cce_comparator_ctrl cce_props cce_props_i (.*);
`default_nettype wire

// ===== tb/cce_analog_model.sv
// behavioural analog comparators and pwm sources beside the block
`timescale 1ns/1ps
`default_nettype none
module cce_analog_model (
    input wire logic [2:0] plus_input_source,
    input wire logic [5:0] minus_input_select,
    input wire logic [23:0] lvl_a,
    input wire logic [23:0] lvl_b,
    input wire logic [23:0] lvl_c,
    input wire logic [23:0] lvl_d,
    input wire logic [7:0] ref_lvl,
    input wire logic [5:0] pwm_set,
    output logic [2:0] cmp_raw,
    output logic pwm_low1,
    output logic pwm_high1,
    output logic pwm_low2,
    output logic pwm_high2,
    output logic pwm_low3,
    output logic pwm_high3
);
    logic [7:0] vp;
    logic [7:0] vm;
    always_comb begin
        vp = '0;
        vm = '0;
        for (int i = 0; i < 3; i++) begin
            vp = plus_input_source[i] ? ref_lvl : lvl_a[8*i +: 8];
            case (minus_input_select[2*i +: 2])
                2'h3: vm = ref_lvl;
                2'h2: vm = lvl_d[8*i +: 8];
                2'h1: vm = lvl_c[8*i +: 8];
                default: vm = lvl_b[8*i +: 8];
            endcase
            // equal levels give low, no hysteresis modelled
            cmp_raw[i] = vp > vm;
        end
    end
    assign {pwm_high3, pwm_low3, pwm_high2, pwm_low2, pwm_high1, pwm_low1} = pwm_set;
endmodule
`default_nettype wire

// ===== tb/test_comparator_control_event_logic.sv
// self-checking bench for the comparator control block
`include "cce_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_comparator_control_event_logic import cce_pkg::*;;
    logic mclk = 1'b0, sys_rst = 1'b1, idle_mode = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic [23:0] lvl_a = 24'h808080, lvl_b = 24'h909090;
    logic [23:0] lvl_c = 24'h101010, lvl_d = 24'h303030;
    logic [7:0] ref_lvl = 8'h50;
    logic [5:0] pwm_set = '0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [2:0] cmp_raw, cmp_active, plus_input_source, result_pin, result_pin_oe;
    wire [2:0] mask_a_source, mask_b_source, mask_c_source, cmp_trigger, cmp_irq;
    wire [5:0] minus_input_select;
    wire pwm_low1, pwm_high1, pwm_low2, pwm_high2, pwm_low3, pwm_high3;
    int bad_count = 0, compares = 0;
    int trig_cnt [3] = '{0, 0, 0};

    cce_comparator_ctrl cce_comparator_ctrl_i (.*);
    cce_analog_model cce_analog_model_i (.*);

    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        for (int i = 0; i < 3; i++) begin
            // a pulse counts only when trigger and irq come together
            if ((cmp_trigger[i] & cmp_irq[i]) === 1'b1) begin
                trig_cnt[i] <= trig_cnt[i] + 1;
            end
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // bready raised only once bvalid is seen, so a held response is exercised
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er,
                      input logic [3:0] s = 4'h3);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [15:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
        chk("rdata", s_axi_rdata, {16'h0000, e});
    endtask

    task automatic report_and_stop;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge mclk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        logic [15:0] w;
        int e, h1, h2, c;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        for (int r = 0; r < 7; r++) rd(8'(4 * r), 2'h0, 16'h0000);
        for (int r = 1; r < 7; r++) begin
            wr(8'(4 * r), 16'h5dff, 2'h0);
            rd(8'(4 * r), 2'h0, r[0] ? 16'h40d3 : 16'h0dff);
            wr(8'(4 * r), 16'h0000, 2'h0);
        end
        wr(8'h1c, 16'hffff, 2'h2);
        rd(8'h1c, 2'h2, 16'h0000);
        rd(8'h02, 2'h2, 16'h0000);
        wr(`CCE_OFS_MSK1, 16'h0fff, 2'h0, 4'h2);
        rd(`CCE_OFS_MSK1, 2'h0, 16'h0f00);
        wr(`CCE_OFS_CTRL3, 16'he2d3, 2'h0, 4'h1);
        rd(`CCE_OFS_CTRL3, 2'h0, 16'h00d3);
        $display("test registers finished");
        for (c = 0; c < 16; c++) begin
            for (int k = 0; k < 3; k++) begin
                wr(8'(`CCE_OFS_MSK1 + 8 * k), {4'h0, 4'(c), 4'(c), 4'(c)}, 2'h0);
            end
            for (int p = 0; p < 2; p++) begin
                pwm_set <= p ? ~(6'h01 << c) : (6'h01 << c);
                repeat (3) @(posedge mclk);
                e = (c < 6) && (p == 0);
                chk("mask_src", 32'({mask_a_source, mask_b_source, mask_c_source}),
                    32'({9{e[0]}}));
            end
        end
        $display("test mask finished");
        for (c = 0; c < 4; c++) begin
            w = 16'h8000 | (16'(c >> 1) << 14) | (16'(c & 1) << 4) | 16'(c);
            wr(`CCE_OFS_CTRL1, w, 2'h0);
            repeat (8) @(posedge mclk);
            e = (c == 1) || (c == 2);
            chk("plus_src", {31'h0, plus_input_source[0]}, 32'(c & 1));
            chk("minus_sel", {30'h0, minus_input_select[1:0]}, 32'(c));
            chk("pin", {30'h0, result_pin_oe[0], result_pin[0]}, 32'((c >> 1) * (2 + e)));
            rd(`CCE_OFS_CTRL1, 2'h0, w | (16'(e) << 8));
            rd(`CCE_OFS_STATUS, 2'h0, 16'(e));
        end
        wr(`CCE_OFS_CTRL1, 16'h0000, 2'h0);
        $display("test inputs finished");
        for (int m = 0; m < 8; m++) begin
            c = m % 3;
            w = 16'h8000 | (16'(m[2]) << 13) | (16'(m[1:0]) << 6);
            wr(8'(4 + 8 * c), w, 2'h0);
            repeat (8) @(posedge mclk);
            e = trig_cnt[c];
            h1 = m[2] ? m[1] : m[0];
            h2 = m[2] ? m[0] : m[1];
            lvl_a[8*c +: 8] <= 8'ha0;
            repeat (8) @(posedge mclk);
            chk("trig_rise", 32'(trig_cnt[c] - e), 32'(h1));
            rd(8'(4 + 8 * c), 2'h0, w | (16'(h1) << 9) | (16'(!m[2]) << 8));
            rd(`CCE_OFS_STATUS, 2'h0, (16'(h1) << (8 + c)) | (16'(!m[2]) << c));
            lvl_a[8*c +: 8] <= 8'h80;
            repeat (8) @(posedge mclk);
            chk("trig_fall", 32'(trig_cnt[c] - e), 32'(h1 | h2));
            wr(8'(4 + 8 * c), 16'h0000, 2'h0);
            rd(`CCE_OFS_STATUS, 2'h0, 16'h0000);
        end
        $display("test events finished");
        wr(`CCE_OFS_CTRL1, 16'h80c0, 2'h0);
        chk("active", {31'h0, cmp_active[0]}, 32'h1);
        wr(`CCE_OFS_STATUS, 16'hffff, 2'h0);
        rd(`CCE_OFS_STATUS, 2'h0, 16'h8000);
        idle_mode <= 1'b1;
        repeat (4) @(posedge mclk);
        e = trig_cnt[0];
        chk("halted", {31'h0, cmp_active[0]}, 32'h0);
        lvl_a[7:0] <= 8'ha0;
        repeat (8) @(posedge mclk);
        chk("idle_trig", 32'(trig_cnt[0] - e), 32'h0);
        wr(`CCE_OFS_STATUS, 16'h0000, 2'h0);
        repeat (4) @(posedge mclk);
        chk("idle_run", {31'h0, cmp_active[0]}, 32'h1);
        idle_mode <= 1'b0;
        $display("test idle finished");
        report_and_stop();
    end
endmodule
`default_nettype wire
